// ==== core/idic_pkg.sv ====
// Purpose: Constants and carrier types for the isolated I/O interrupt control block
// Assumes: 200 MHz card clock, byte-wide host port
// Notes: Register offsets are byte offsets from the card base
package idic_pkg;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int unsigned CLK_FREQ_HZ = 200_000_000;
	localparam int unsigned REF_FREQ_HZ = 10_000_000;
	localparam int unsigned EVT_MAX_FREQ_HZ = 1_000_000;
	localparam int unsigned REF_DIV_CYCLES = CLK_FREQ_HZ / REF_FREQ_HZ;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [5:0] OFS_DIO_LO = 6'h00;
	localparam logic [5:0] OFS_DIO_HI = 6'h01;
	localparam logic [5:0] OFS_CNT0 = 6'h18;
	localparam logic [5:0] OFS_CNT1 = 6'h19;
	localparam logic [5:0] OFS_CNT2 = 6'h1a;
	localparam logic [5:0] OFS_CNT_CTRL = 6'h1b;
	localparam logic [5:0] OFS_INT_CTRL = 6'h20;
	localparam logic [5:0] OFS_SOFT_RESET = 6'h21;

	// ************************************************************
	// Interrupt control register fields
	// ************************************************************
	localparam int unsigned G0_SEL_LSB = 0;
	localparam int unsigned G0_EDGE_BIT = 2;
	localparam int unsigned G0_FLAG_BIT = 3;
	localparam int unsigned G1_SEL_LSB = 4;
	localparam int unsigned G1_EDGE_BIT = 6;
	localparam int unsigned G1_FLAG_BIT = 7;

	localparam logic [1:0] SEL_OFF = 2'h0;
	localparam logic [1:0] SEL_PRIMARY = 2'h1;
	localparam logic [1:0] SEL_GATED = 2'h2;
	localparam logic [1:0] SEL_COUNTER = 2'h3;

	// Input channel roles
	localparam int unsigned IN_G0_TRIG = 0;
	localparam int unsigned IN_G0_GATE = 4;
	localparam int unsigned IN_G1_TRIG = 8;
	localparam int unsigned IN_G1_GATE = 12;
	localparam int unsigned IN_EVENT = 15;

	// Counter control word fields
	localparam int unsigned CW_SEL_LSB = 6;
	localparam int unsigned CW_RW_LSB = 4;
	localparam logic [1:0] CW_RW_LATCH = 2'h0;

	localparam logic [7:0] RESET_INT_CTRL = 8'h00;
	localparam logic [15:0] RESET_COUNT = 16'hffff;

	typedef struct packed {
		logic [5:0] addr;
		logic wr;
		logic rd;
		logic [7:0] wdata;
	} idic_host_req_t;

	typedef struct packed {
		logic [1:0] sel;
		logic edge_rise;
	} idic_group_cfg_t;

endpackage : idic_pkg

// ==== core/idic_top.sv ====
// Purpose: Isolated digital I/O with timer/counter and two-group interrupt control
// Assumes: Host byte port is synchronous to clk; field inputs are asynchronous
// Notes: Read data appears one cycle after the read strobe
`timescale 1ns/1ps
module idic_top
	import idic_pkg::*;
#(
	parameter int unsigned CHANNELS = 16,
	parameter int unsigned CNT_WIDTH = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [5:0] host_addr,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	input wire logic [CHANNELS-1:0] isolated_input,
	output logic [CHANNELS-1:0] isolated_output,
	output logic host_irq
);

	// ************************************************************
	// Functions
	// ************************************************************
	function automatic logic idic_edge(input logic cur, input logic prev, input logic rise);
		idic_edge = rise ? (cur & ~prev) : (~cur & prev);
	endfunction : idic_edge

	function automatic logic [7:0] idic_byte(input logic [CNT_WIDTH-1:0] val, input logic hi);
		idic_byte = hi ? val[15:8] : val[7:0];
	endfunction : idic_byte

	// ************************************************************
	// Host request decode
	// ************************************************************
	idic_host_req_t req;
	assign req = '{addr: host_addr, wr: host_wr, rd: host_rd, wdata: host_wdata};

	wire wr_dio_lo = req.wr && (req.addr == OFS_DIO_LO);
	wire wr_dio_hi = req.wr && (req.addr == OFS_DIO_HI);
	wire wr_int_ctrl = req.wr && (req.addr == OFS_INT_CTRL);
	wire wr_soft_reset = req.wr && (req.addr == OFS_SOFT_RESET);
	wire wr_cnt_ctrl = req.wr && (req.addr == OFS_CNT_CTRL);
	wire [2:0] wr_cnt;
	wire [2:0] rd_cnt;
	assign wr_cnt = {req.wr && (req.addr == OFS_CNT2), req.wr && (req.addr == OFS_CNT1),
		req.wr && (req.addr == OFS_CNT0)};
	assign rd_cnt = {req.rd && (req.addr == OFS_CNT2), req.rd && (req.addr == OFS_CNT1),
		req.rd && (req.addr == OFS_CNT0)};

	// ************************************************************
	// Field input synchroniser
	// ************************************************************
	// Second and third stages feed the edge detectors; stage one stays private
	logic [CHANNELS-1:0] in_meta;
	logic [CHANNELS-1:0] in_sync;
	logic [CHANNELS-1:0] in_prev;

	always_ff @(posedge clk) begin
		in_meta <= isolated_input;
		in_sync <= in_meta;
		in_prev <= in_sync;
	end

	// ************************************************************
	// Isolated outputs
	// ************************************************************
	logic [CHANNELS-1:0] next_output;

	always_comb begin
		next_output = isolated_output;
		if (wr_dio_lo) begin
			next_output[7:0] = req.wdata;
		end
		if (wr_dio_hi) begin
			next_output[15:8] = req.wdata;
		end
		if (wr_soft_reset) begin
			next_output = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			isolated_output <= '0;
		end else begin
			isolated_output <= next_output;
		end
	end

	// ************************************************************
	// Reference tick
	// ************************************************************
	localparam int unsigned DIV_W = $clog2(REF_DIV_CYCLES);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(REF_DIV_CYCLES - 1);
	logic [DIV_W-1:0] ref_div;
	wire ref_tick = (ref_div == DIV_LAST);

	always_ff @(posedge clk) begin
		if (reset) begin
			ref_div <= '0;
		end else begin
			ref_div <= ref_tick ? '0 : ref_div + 1'b1;
		end
	end

	// ************************************************************
	// Timer/counter channels
	// ************************************************************
	// Square wave: output toggles each expiry, so period is twice the count.
	// Gates are not modelled as inputs; they are always active.
	logic [2:0] cnt_out;
	logic [2:0] cnt_out_prev;
	logic [2:0] cnt_en;
	logic [CNT_WIDTH-1:0] cnt_val [3];
	logic [CNT_WIDTH-1:0] cnt_reload [3];
	logic [2:0] wr_hi_byte;
	logic [2:0] rd_hi_byte;
	wire [1:0] cw_sel = req.wdata[CW_SEL_LSB +: 2];
	wire cw_latch = (req.wdata[CW_RW_LSB +: 2] == CW_RW_LATCH);

	assign cnt_en[0] = ref_tick;
	assign cnt_en[1] = cnt_out[0] & ~cnt_out_prev[0];
	assign cnt_en[2] = in_sync[IN_EVENT] & ~in_prev[IN_EVENT];

	always_ff @(posedge clk) begin
		if (reset) begin
			// Same level as the reset output, so no false edge
			cnt_out_prev <= '1;
		end else begin
			cnt_out_prev <= cnt_out;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_cnt
			wire cw_hit = wr_cnt_ctrl && (cw_sel == 2'(gi));
			wire expire = cnt_val[gi] <= CNT_WIDTH'(1);

			always_ff @(posedge clk) begin
				if (reset) begin
					cnt_reload[gi] <= RESET_COUNT;
					cnt_val[gi] <= RESET_COUNT;
					cnt_out[gi] <= 1'b1;
					wr_hi_byte[gi] <= 1'b0;
					rd_hi_byte[gi] <= 1'b0;
				end else begin
					if (wr_cnt[gi]) begin
						wr_hi_byte[gi] <= ~wr_hi_byte[gi];
						if (wr_hi_byte[gi]) begin
							cnt_reload[gi][15:8] <= req.wdata;
							cnt_val[gi] <= {req.wdata, cnt_reload[gi][7:0]};
							cnt_out[gi] <= 1'b1;
						end else begin
							cnt_reload[gi][7:0] <= req.wdata;
						end
					end else if (cnt_en[gi]) begin
						if (expire) begin
							cnt_val[gi] <= cnt_reload[gi];
							cnt_out[gi] <= ~cnt_out[gi];
						end else begin
							cnt_val[gi] <= cnt_val[gi] - 1'b1;
						end
					end
					if (cw_hit && cw_latch) begin
						rd_hi_byte[gi] <= 1'b0;
						wr_hi_byte[gi] <= 1'b0;
					end else if (rd_cnt[gi]) begin
						rd_hi_byte[gi] <= ~rd_hi_byte[gi];
					end
				end
			end
		end
	endgenerate

	// ************************************************************
	// Interrupt control register
	// ************************************************************
	idic_group_cfg_t g0_cfg;
	idic_group_cfg_t g1_cfg;
	logic group0_pending_flag;
	logic group1_pending_flag;

	always_ff @(posedge clk) begin
		if (reset) begin
			g0_cfg <= '{sel: RESET_INT_CTRL[G0_SEL_LSB +: 2], edge_rise: RESET_INT_CTRL[G0_EDGE_BIT]};
			g1_cfg <= '{sel: RESET_INT_CTRL[G1_SEL_LSB +: 2], edge_rise: RESET_INT_CTRL[G1_EDGE_BIT]};
		end else if (wr_int_ctrl) begin
			g0_cfg <= '{sel: req.wdata[G0_SEL_LSB +: 2], edge_rise: req.wdata[G0_EDGE_BIT]};
			g1_cfg <= '{sel: req.wdata[G1_SEL_LSB +: 2], edge_rise: req.wdata[G1_EDGE_BIT]};
		end
	end

	// ************************************************************
	// Source selection and edge detection
	// ************************************************************
	wire g0_trig_edge = idic_edge(in_sync[IN_G0_TRIG], in_prev[IN_G0_TRIG], g0_cfg.edge_rise);
	wire g1_trig_edge = idic_edge(in_sync[IN_G1_TRIG], in_prev[IN_G1_TRIG], g1_cfg.edge_rise);
	wire g0_cnt_edge = idic_edge(cnt_out[1], cnt_out_prev[1], g0_cfg.edge_rise);
	wire g1_cnt_edge = idic_edge(cnt_out[2], cnt_out_prev[2], g1_cfg.edge_rise);
	wire group0_gate_input = in_sync[IN_G0_GATE];
	wire group1_gate_input = in_sync[IN_G1_GATE];

	logic g0_event;
	logic g1_event;

	always_comb begin
		unique case (g0_cfg.sel)
			SEL_OFF: g0_event = 1'b0;
			SEL_PRIMARY: g0_event = g0_trig_edge;
			SEL_GATED: g0_event = g0_trig_edge & group0_gate_input;
			SEL_COUNTER: g0_event = g0_cnt_edge;
		endcase
	end

	always_comb begin
		unique case (g1_cfg.sel)
			SEL_OFF: g1_event = 1'b0;
			SEL_PRIMARY: g1_event = g1_trig_edge;
			SEL_GATED: g1_event = g1_trig_edge & group1_gate_input;
			SEL_COUNTER: g1_event = g1_cnt_edge;
		endcase
	end

	// ************************************************************
	// Pending flags
	// ************************************************************
	// A new event in the clearing cycle wins, so no edge is lost
	wire g0_clear = wr_int_ctrl & req.wdata[G0_FLAG_BIT];
	wire g1_clear = wr_int_ctrl & req.wdata[G1_FLAG_BIT];

	always_ff @(posedge clk) begin
		if (reset) begin
			group0_pending_flag <= RESET_INT_CTRL[G0_FLAG_BIT];
			group1_pending_flag <= RESET_INT_CTRL[G1_FLAG_BIT];
		end else begin
			group0_pending_flag <= g0_event | (group0_pending_flag & ~g0_clear);
			group1_pending_flag <= g1_event | (group1_pending_flag & ~g1_clear);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			host_irq <= 1'b0;
		end else begin
			host_irq <= group0_pending_flag | group1_pending_flag;
		end
	end

	// ************************************************************
	// Read data
	// ************************************************************
	wire [7:0] int_status = {group1_pending_flag, g1_cfg.edge_rise, g1_cfg.sel,
		group0_pending_flag, g0_cfg.edge_rise, g0_cfg.sel};
	logic [7:0] next_rdata;

	always_comb begin
		unique case (req.addr)
			OFS_DIO_LO: next_rdata = in_sync[7:0];
			OFS_DIO_HI: next_rdata = in_sync[15:8];
			OFS_CNT0: next_rdata = idic_byte(cnt_val[0], rd_hi_byte[0]);
			OFS_CNT1: next_rdata = idic_byte(cnt_val[1], rd_hi_byte[1]);
			OFS_CNT2: next_rdata = idic_byte(cnt_val[2], rd_hi_byte[2]);
			OFS_INT_CTRL: next_rdata = int_status;
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			host_rdata <= 8'h00;
		end else if (req.rd) begin
			host_rdata <= next_rdata;
		end
	end

endmodule : idic_top

// ==== sim/idic_monitor.sv ====
// Purpose: Port checker for the interrupt control block
// Assumes: Synchronous active-high reset, one clock
// Notes: Bound to every idic_top instance
`timescale 1ns/1ps
module idic_monitor import idic_pkg::*; #(
	parameter int unsigned CHANNELS = 16
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [5:0] host_addr,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [7:0] host_wdata,
	input wire logic [7:0] host_rdata,
	input wire logic [CHANNELS-1:0] isolated_output,
	input wire logic host_irq
);
	// ***************
	// Checks
	// ***************
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire wr_ctrl = host_wr && host_addr == OFS_INT_CTRL;
	wire rd_ctrl = host_rd && host_addr == OFS_INT_CTRL;
	a_reset_quiet: assert property ($fell(reset) |-> !host_irq && isolated_output == '0)
		else $error("outputs not idle after reset");
	a_soft_clear: assert property (host_wr && host_addr == OFS_SOFT_RESET |=> isolated_output == '0)
		else $error("soft reset left outputs set");
	a_out_low: assert property (host_wr && host_addr == OFS_DIO_LO |=> isolated_output[7:0] == $past(host_wdata))
		else $error("output byte not written");
	a_rd_unmapped: assert property (host_rd && host_addr == 6'h3f |=> host_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!host_rd |=> $stable(host_rdata))
		else $error("read data moved without a read");
	a_ctrl_echo: assert property (wr_ctrl ##2 rd_ctrl |=> (host_rdata & 8'h77) == ($past(host_wdata, 3) & 8'h77))
		else $error("control bits not read back");
	a_irq_mirror: assert property (rd_ctrl |=> host_irq == (host_rdata[7] | host_rdata[3]))
		else $error("request line disagrees with flags");
	a_irq_holds: assert property (host_irq && !wr_ctrl && !$past(wr_ctrl) |=> host_irq)
		else $error("request dropped without a clear");
endmodule : idic_monitor
bind idic_top idic_monitor #(.CHANNELS(CHANNELS)) mon_u (.clk(clk), .reset(reset), .host_addr(host_addr),
	.host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata(host_rdata),
	.isolated_output(isolated_output), .host_irq(host_irq));

// ==== sim/idic_field_model.sv ====
// Purpose: Field wiring feeding the isolated inputs
// Assumes: Field levels change with no relation to the card clock
// Notes: Fixed isolation lag, no contact bounce
`timescale 1ns/1ps
module idic_field_model (
	input wire logic [15:0] field_level,
	output wire logic [15:0] pins
);
	// ***************
	// Isolation path
	// ***************
	// Odd lag keeps pin edges off the clock edges
	assign #2.3 pins = field_level;
endmodule : idic_field_model

// ==== sim/isolated_dio_interrupt_control_test.sv ====
// Purpose: Self-checking bench for the interrupt control block
// Assumes: One-cycle host strobes with an idle cycle between
// Notes: Read results are checked in order from a queue
`timescale 1ns/1ps
module isolated_dio_interrupt_control_test import idic_pkg::*;;
	// ***************
	// Stimulus and checking
	// ***************
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [5:0] host_addr = 6'h00;
	logic host_wr = 1'b0;
	logic host_rd = 1'b0;
	logic [7:0] host_wdata = 8'h00;
	logic [7:0] host_rdata;
	logic [15:0] field = 16'h0000;
	logic [15:0] pins;
	logic [15:0] isolated_output;
	logic host_irq;
	logic [7:0] exp_q[$];
	logic rd_q = 1'b0;
	logic [7:0] cfg;
	int errors = 0;
	int checked = 0;
	int cycles = 0;
	always #2.5 clk = ~clk;
	idic_field_model fld_u (.field_level(field), .pins(pins));
	idic_top dut_u (.clk(clk), .reset(reset), .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
		.host_wdata(host_wdata), .host_rdata(host_rdata), .isolated_input(pins),
		.isolated_output(isolated_output), .host_irq(host_irq));
	task automatic end_of_test();
		$display("checks %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_of_test
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : settle
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		settle(1);
		host_wr = 1'b0;
		settle(1);
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		host_addr = a;
		host_rd = 1'b1;
		settle(1);
		host_rd = 1'b0;
		settle(1);
	endtask : rd
	// Wrong edge last, so it must leave the flag clear
	task automatic trial(input int g, input logic [1:0] sel, input logic rise, input logic gate);
		logic fire;
		fire = sel == SEL_PRIMARY || (sel == SEL_GATED && gate);
		cfg = 8'({rise, sel}) << (4 * g);
		field[8 * g] = ~rise;
		field[8 * g + 4] = gate;
		settle(6);
		wr(OFS_INT_CTRL, cfg | 8'h88);
		field[8 * g] = rise;
		settle(6);
		rd(OFS_INT_CTRL, cfg | (fire ? 8'h08 << (4 * g) : 8'h00));
		check(16'(host_irq), 16'(fire));
		wr(OFS_INT_CTRL, cfg | 8'h88);
		field[8 * g] = ~rise;
		settle(6);
		rd(OFS_INT_CTRL, cfg);
	endtask : trial
	always @(posedge clk) begin
		if (rd_q) begin
			check({8'h00, host_rdata}, {8'h00, exp_q.pop_front()});
		end
		rd_q = host_rd;
		cycles++;
		if (cycles == 10000) begin
			errors++;
			end_of_test();
		end
	end
	initial begin
		void'($urandom(32'h3727_ecd8));
		settle(10);
		reset = 1'b0;
		check(isolated_output, 16'h0000);
		check(16'(host_irq), 16'h0000);
		rd(OFS_INT_CTRL, RESET_INT_CTRL);
		field = 16'($urandom());
		wr(OFS_DIO_LO, field[15:8]);
		wr(OFS_DIO_HI, field[7:0]);
		settle(6);
		rd(OFS_DIO_LO, field[7:0]);
		rd(OFS_DIO_HI, field[15:8]);
		check(isolated_output, {field[7:0], field[15:8]});
		rd(6'h3f, 8'h00);
		wr(OFS_SOFT_RESET, 8'h5a);
		check(isolated_output, 16'h0000);
		field = 16'h0000;
		for (int i = 0; i < 24; i++) begin
			trial(i / 12, 2'(i % 3), i[1], i[0]);
		end
		field = 16'h0000;
		settle(6);
		wr(OFS_INT_CTRL, 8'hdd);
		field = 16'h0101;
		settle(6);
		rd(OFS_INT_CTRL, 8'hdd);
		wr(OFS_INT_CTRL, 8'h5d);
		rd(OFS_INT_CTRL, 8'hd5);
		check(16'(host_irq), 16'h0001);
		wr(OFS_INT_CTRL, 8'hd5);
		rd(OFS_INT_CTRL, 8'h55);
		check(16'(host_irq), 16'h0000);
		for (int i = 0; i < 3; i++) begin
			wr(OFS_CNT0 + 6'(i), 8'h02);
			wr(OFS_CNT0 + 6'(i), 8'h00);
		end
		wr(OFS_INT_CTRL, 8'hff);
		repeat (8) begin
			field[15] = 1'b1;
			settle(100);
			field[15] = 1'b0;
			settle(100);
		end
		rd(OFS_INT_CTRL, 8'hff);
		rd(OFS_CNT2, 8'h02);
		rd(OFS_CNT2, 8'h00);
		wr(OFS_CNT_CTRL, 8'h80);
		rd(OFS_CNT2, 8'h02);
		end_of_test();
	end
endmodule : isolated_dio_interrupt_control_test
